// File: shared/clock_status_regs.svh
// Register offsets, field positions, reset values and timing counts
// for the clock input status and alarm register bank.
// Assumes inclusion by bare name from the design file and the testbench.
`ifndef CLOCK_STATUS_REGS_SVH
`define CLOCK_STATUS_REGS_SVH

// ****************************************************************
// Register offsets (8-bit register address space)
// ****************************************************************
`define DIV_HIGH_OFFSET 8'h2E
`define DIV_MID_OFFSET 8'h2F
`define DIV_LOW_OFFSET 8'h30
`define ACTIVE_INPUT_OFFSET 8'h80
`define LIVE_LOSS_OFFSET 8'h81
`define LIVE_LOCK_OFFSET 8'h82
`define STICKY_LOSS_OFFSET 8'h83
`define STICKY_LOCK_OFFSET 8'h84
`define PART_ID_HIGH_OFFSET 8'h86
`define PART_ID_LOW_REV_OFFSET 8'h87

// ****************************************************************
// Field positions
// ****************************************************************
`define FIRST_ACTIVE_BIT 0
`define SECOND_ACTIVE_BIT 1
`define STATUS_PENDING_BIT 5
`define REF_LOSS_BIT 0
`define FIRST_LOSS_BIT 1
`define SECOND_LOSS_BIT 2
`define UNLOCK_LIVE_BIT 0
`define UNLOCK_STICKY_BIT 1
`define DIV_HIGH_WIDTH 3

// ****************************************************************
// Reset values
// ****************************************************************
`define ACTIVE_INPUT_RESET 8'h20
`define STICKY_LOCK_RESET 8'h02
`define STICKY_LOSS_RESET 3'h0
`define DIV_RESET 19'h00000

// ****************************************************************
// Timing counts
// ****************************************************************
`define SYNC_STAGES 2

`endif

// File: shared/clock_status_pkg.sv
// Types shared by the clock input status register bank.
// Uses nothing from the constants header and does not include it.
package clock_status_pkg;

  // Which clock input the PLL has selected
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_FIRST,
    SEL_SECOND
  } input_select_type;

  // Live alarm indications from the clock monitors
  typedef struct packed {
    logic second_input_signal_missing;
    logic first_input_signal_missing;
    logic reference_signal_missing;
    logic pll_unlocked;
  } alarm_type;

  // Per-flag interrupt masks, 1 masks the flag
  typedef struct packed {
    logic second_input_alarm_mask;
    logic first_input_alarm_mask;
    logic reference_alarm_mask;
    logic unlock_alarm_mask;
  } alarm_mask_type;

  // Register access request from the serial port front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

endpackage : clock_status_pkg

// File: design/clock_input_status_flags.sv
// Status and alarm register bank of the clock multiplier: active input,
// live and sticky alarms, interrupt output, second input divider, identity.
// Assumes the serial configuration port front end hands over decoded
// register reads and writes on clk_i; monitor inputs are asynchronous.
`timescale 1ns/1ps
`include "clock_status_regs.svh"

// Overview of operation
// - Register 48 holds divider low byte; zero divides by 1
// - Divider upper bits in registers 46 and 47
// - Active bit 1 set when second input drives PLL
// - Active bit 0 set when first input drives PLL
// - Live loss bit 2 follows second input alarm
// - Live loss bit 1 follows first input alarm
// - Live loss bit 0 follows reference alarm
// - Live lock bit 0 is 1 when unlocked
// - Sticky loss flags capture and hold live alarms
// - Sticky unlock flag captures and holds lock loss
// - Interrupt needs enable bit and unmasked set flag
// - Writing 0 to a sticky flag clears it
// - Reset reads 0x20 active and 0x02 lock flag
module clock_input_status_flags #(
  parameter logic [11:0] PART_ID = 12'hA5C, // Arbitrary value
  parameter logic [3:0] REVISION = 4'h3 // Arbitrary value
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire clock_status_pkg::reg_req_type req_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  input wire clock_status_pkg::input_select_type input_select_i,
  input wire clock_status_pkg::alarm_type alarm_i,
  input wire clock_status_pkg::alarm_mask_type alarm_mask_i,
  input wire logic interrupt_enable_i,
  output logic [19:0] second_input_divide_ratio_o,
  output logic int_o
);

  // ****************************************************************
  // Synchronisers for monitor and selection inputs
  // ****************************************************************
  logic [3:0] alarm_meta_reg; // First stage, read only by second stage and the live readout assertions
  clock_status_pkg::alarm_type alarm_sync_reg; // Usable alarm levels
  logic [1:0] select_meta_reg; // First stage of selection
  logic [1:0] select_sync_reg; // Usable selection
  logic [1:0] settle_count_reg; // Cycles since reset release

  // Two flops on every asynchronous level; a multi-bit select can show a
  // one-cycle mix during a switch, harmless for a status readout
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_meta_reg <= 4'h0;
      alarm_sync_reg <= '0;
      select_meta_reg <= 2'h0;
      select_sync_reg <= 2'h0;
    end else begin
      alarm_meta_reg <= alarm_i;
      alarm_sync_reg <= alarm_meta_reg;
      select_meta_reg <= input_select_i;
      select_sync_reg <= select_meta_reg;
    end
  end

  // Status is not trusted until the synchronisers have filled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      settle_count_reg <= 2'h0;
    end else if (settle_count_reg != 2'(`SYNC_STAGES)) begin
      settle_count_reg <= settle_count_reg + 2'h1;
    end
  end

  logic settled; // Synchronisers hold real samples
  assign settled = (settle_count_reg == 2'(`SYNC_STAGES));

  // ****************************************************************
  // Write decode
  // ****************************************************************
  logic wr_div_high; // Divider bits 18:16
  logic wr_div_mid; // Divider bits 15:8
  logic wr_div_low; // Divider bits 7:0
  logic wr_sticky_loss; // Sticky loss flags
  logic wr_sticky_lock; // Sticky unlock flag
  assign wr_div_high = req_i.wr && (req_i.addr == `DIV_HIGH_OFFSET);
  assign wr_div_mid = req_i.wr && (req_i.addr == `DIV_MID_OFFSET);
  assign wr_div_low = req_i.wr && (req_i.addr == `DIV_LOW_OFFSET);
  assign wr_sticky_loss = req_i.wr && (req_i.addr == `STICKY_LOSS_OFFSET);
  assign wr_sticky_lock = req_i.wr && (req_i.addr == `STICKY_LOCK_OFFSET);

  // ****************************************************************
  // Second input divider
  // ****************************************************************
  logic [18:0] divider_reg; // Programmed divider value

  // Each byte lands in its own slice; reserved bits 7:3 of the top byte drop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      divider_reg <= `DIV_RESET;
    end else begin
      if (wr_div_high) begin
        divider_reg[18:16] <= req_i.wdata[`DIV_HIGH_WIDTH-1:0];
      end
      if (wr_div_mid) begin
        divider_reg[15:8] <= req_i.wdata;
      end
      if (wr_div_low) begin
        divider_reg[7:0] <= req_i.wdata;
      end
    end
  end

  // Ratio is value plus one, so zero divides by 1 and all ones by 2^19
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      second_input_divide_ratio_o <= 20'h00001;
    end else begin
      second_input_divide_ratio_o <= {1'b0, divider_reg} + 20'h00001;
    end
  end

  // ****************************************************************
  // Active input status
  // ****************************************************************
  logic [7:0] active_reg; // Active input readout

  // An input is active only when selected and not reporting loss
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_reg <= `ACTIVE_INPUT_RESET;
    end else if (settled) begin
      active_reg <= 8'h00;
      active_reg[`SECOND_ACTIVE_BIT] <= (select_sync_reg == clock_status_pkg::SEL_SECOND)
        && !alarm_sync_reg.second_input_signal_missing;
      active_reg[`FIRST_ACTIVE_BIT] <= (select_sync_reg == clock_status_pkg::SEL_FIRST)
        && !alarm_sync_reg.first_input_signal_missing;
    end
  end

  // ****************************************************************
  // Live alarm readouts
  // ****************************************************************
  logic [7:0] live_loss; // Live loss readout
  logic [7:0] live_lock; // Live lock readout
  always_comb begin
    live_loss = 8'h00;
    live_loss[`SECOND_LOSS_BIT] = alarm_sync_reg.second_input_signal_missing;
    live_loss[`FIRST_LOSS_BIT] = alarm_sync_reg.first_input_signal_missing;
    live_loss[`REF_LOSS_BIT] = alarm_sync_reg.reference_signal_missing;
    live_lock = 8'h00;
    live_lock[`UNLOCK_LIVE_BIT] = alarm_sync_reg.pll_unlocked;
  end

  // ****************************************************************
  // Sticky flags
  // ****************************************************************
  logic [2:0] sticky_loss_reg; // Held loss alarms
  logic sticky_lock_reg; // Held lock loss
  logic [2:0] sticky_loss_next;
  logic sticky_lock_next;

  // Writing 0 clears, writing 1 keeps; a live alarm in the clearing cycle
  // wins so that no event is lost
  always_comb begin
    sticky_loss_next = sticky_loss_reg;
    if (wr_sticky_loss) begin
      sticky_loss_next = sticky_loss_reg & req_i.wdata[2:0];
    end
    sticky_loss_next = sticky_loss_next | live_loss[2:0];
    sticky_lock_next = sticky_lock_reg;
    if (wr_sticky_lock) begin
      sticky_lock_next = sticky_lock_reg & req_i.wdata[`UNLOCK_STICKY_BIT];
    end
    sticky_lock_next = sticky_lock_next | alarm_sync_reg.pll_unlocked;
  end

  // Unlock flag starts set: the PLL has not locked out of reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sticky_loss_reg <= `STICKY_LOSS_RESET;
      sticky_lock_reg <= 1'b1;
    end else begin
      sticky_loss_reg <= sticky_loss_next;
      sticky_lock_reg <= sticky_lock_next;
    end
  end

  // ****************************************************************
  // Interrupt output
  // ****************************************************************
  logic [3:0] pending; // Unmasked set flags
  assign pending = {sticky_loss_reg, sticky_lock_reg} & ~alarm_mask_i;

  // Registered so the pin never glitches on mask changes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_o <= 1'b0;
    end else begin
      int_o <= interrupt_enable_i && (pending != 4'h0);
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [7:0] read_mux; // Selected register

  // Unmapped addresses read zero; reserved bits are built as zero
  always_comb begin
    case (req_i.addr)
      `DIV_HIGH_OFFSET: read_mux = {5'h00, divider_reg[18:16]};
      `DIV_MID_OFFSET: read_mux = divider_reg[15:8];
      `DIV_LOW_OFFSET: read_mux = divider_reg[7:0];
      `ACTIVE_INPUT_OFFSET: read_mux = active_reg;
      `LIVE_LOSS_OFFSET: read_mux = live_loss;
      `LIVE_LOCK_OFFSET: read_mux = live_lock;
      `STICKY_LOSS_OFFSET: read_mux = {5'h00, sticky_loss_reg};
      `STICKY_LOCK_OFFSET: read_mux = {6'h00, sticky_lock_reg, 1'b0};
      `PART_ID_HIGH_OFFSET: read_mux = PART_ID[11:4];
      `PART_ID_LOW_REV_OFFSET: read_mux = {PART_ID[3:0], REVISION};
      default: read_mux = 8'h00;
    endcase
  end

  // Read data returns one cycle after the strobe and holds until the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd;
      if (req_i.rd) begin
        rdata_o <= read_mux;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_div_ratio;
    $rose(wr_div_low) && (req_i.wdata == 8'h00) && (divider_reg[18:8] == 11'h000)
      |-> ##2 (second_input_divide_ratio_o == 20'h00001);
  endproperty
  a_div_ratio: assert property (p_div_ratio) else $error("zero divider not divide by 1");

  property p_div_high;
    wr_div_high |=> (divider_reg[18:16] == $past(req_i.wdata[2:0]));
  endproperty
  a_div_high: assert property (p_div_high) else $error("divider high bits not stored");

  property p_second_active;
    settled && $past(settled) && alarm_sync_reg.second_input_signal_missing
      |=> !active_reg[`SECOND_ACTIVE_BIT];
  endproperty
  a_second_active: assert property (p_second_active) else $error("second active on loss");

  property p_first_active;
    settled && (select_sync_reg == clock_status_pkg::SEL_FIRST)
      && !alarm_sync_reg.first_input_signal_missing |=> active_reg[`FIRST_ACTIVE_BIT];
  endproperty
  a_first_active: assert property (p_first_active) else $error("first input not active");

  property p_sticky_loss_hold;
    sticky_loss_reg[2] && !(wr_sticky_loss && !req_i.wdata[2]) |=> sticky_loss_reg[2];
  endproperty
  a_sticky_loss_hold: assert property (p_sticky_loss_hold) else $error("loss flag lost");

  property p_sticky_lock_set;
    alarm_sync_reg.pll_unlocked |=> sticky_lock_reg;
  endproperty
  a_sticky_lock_set: assert property (p_sticky_lock_set) else $error("unlock not held");

  property p_int_gate;
    !interrupt_enable_i |=> !int_o;
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("interrupt while disabled");

  property p_int_fire;
    interrupt_enable_i && sticky_lock_reg && !alarm_mask_i.unlock_alarm_mask |=> int_o;
  endproperty
  a_int_fire: assert property (p_int_fire) else $error("unmasked flag no interrupt");

  property p_clear;
    wr_sticky_lock && !req_i.wdata[1] && !alarm_sync_reg.pll_unlocked |=> !sticky_lock_reg;
  endproperty
  a_clear: assert property (p_clear) else $error("unlock flag not cleared");

  property p_reserved_zero;
    rvalid_o && $past(req_i.addr) == `STICKY_LOCK_OFFSET |-> (rdata_o & 8'hFD) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  // Live readouts trail the first synchroniser stage by exactly one edge,
  // so these also catch a swapped bit position in the readout
  property p_second_loss_live;
    live_loss[`SECOND_LOSS_BIT] == $past(alarm_meta_reg[3]);
  endproperty
  a_second_loss_live: assert property (p_second_loss_live) else $error("second loss wrong");

  property p_first_loss_live;
    live_loss[`FIRST_LOSS_BIT] == $past(alarm_meta_reg[2]);
  endproperty
  a_first_loss_live: assert property (p_first_loss_live) else $error("first loss wrong");

  property p_ref_loss_live;
    live_loss[`REF_LOSS_BIT] == $past(alarm_meta_reg[1]);
  endproperty
  a_ref_loss_live: assert property (p_ref_loss_live) else $error("reference loss wrong");

  property p_unlock_live;
    live_lock[`UNLOCK_LIVE_BIT] == $past(alarm_meta_reg[0]);
  endproperty
  a_unlock_live: assert property (p_unlock_live) else $error("unlock readout wrong");

  property p_sticky_loss_set;
    (live_loss[2:0] != 3'h0)
      |=> ((sticky_loss_reg & $past(live_loss[2:0])) == $past(live_loss[2:0]));
  endproperty
  a_sticky_loss_set: assert property (p_sticky_loss_set) else $error("loss not captured");

  property p_loss_clear;
    wr_sticky_loss && (req_i.wdata[2:0] == 3'h0) && (live_loss[2:0] == 3'h0)
      |=> (sticky_loss_reg == 3'h0);
  endproperty
  a_loss_clear: assert property (p_loss_clear) else $error("loss flags not cleared");

  property p_reset_values;
    $past(rst_i) |-> (active_reg == `ACTIVE_INPUT_RESET) && sticky_lock_reg;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset value wrong");

  property p_part_id;
    rvalid_o && ($past(req_i.addr) == `PART_ID_HIGH_OFFSET) |-> (rdata_o == PART_ID[11:4]);
  endproperty
  a_part_id: assert property (p_part_id) else $error("part id readout wrong");

  c_clear_flag: cover property (sticky_loss_reg[1] ##1 wr_sticky_loss ##1 !sticky_loss_reg[1]);
  c_int_pulse: cover property (!int_o ##1 int_o ##[1:20] !int_o);
  c_second_active: cover property (active_reg[`SECOND_ACTIVE_BIT]);
  c_set_wins: cover property (wr_sticky_lock && !req_i.wdata[1] && alarm_sync_reg.pll_unlocked);
  c_lock_interrupt: cover property (int_o && sticky_lock_reg);

endmodule : clock_input_status_flags

// File: tb/config_host_model.sv
// Host controller model on the serial configuration port of the status bank.
// Assumes callers enter each task just after a rising edge of clk_i.
`timescale 1ns/1ps
module config_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output clock_status_pkg::reg_req_type req_o
);
  // ********
  // Bus cycles
  // ********
  // Idle request at time zero
  initial begin
    req_o = '0;
  end

  // One write strobe, taken at the next edge
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge clk_i);
    req_o <= '0;
    // Idle edge so that a following strobe never lands in this time step
    @(posedge clk_i);
  endtask : write_reg

  // Read strobe, then a bounded wait for the valid pulse
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    ok = 1'b0;
    data = 8'h00;
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge clk_i);
    req_o <= '0;
    // Sampled on the edge, so the pulse of the previous cycle is seen
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk_i);
      if (rvalid_i === 1'b1) begin
        data = rdata_i;
        ok = 1'b1;
      end
    end
  endtask : read_reg

  // Acknowledge by writing 0 to chosen flags, 1 elsewhere
  task automatic ack_flags(input logic [7:0] addr, input logic [7:0] clear_bits);
    write_reg(addr, ~clear_bits);
  endtask : ack_flags
endmodule : config_host_model

// File: tb/clock_input_status_flags_tb.sv
// Self-checking bench for the clock input status and alarm register bank.
// Assumes the constants header is on the include path and a 100 MHz clock.
`timescale 1ns/1ps
`include "clock_status_regs.svh"
module clock_input_status_flags_tb;
  localparam logic [11:0] PART_ID = 12'h5C3; // Arbitrary value
  localparam logic [3:0] REVISION = 4'h9; // Arbitrary value
  logic clk_i;
  logic rst_i;
  clock_status_pkg::reg_req_type req;
  logic [7:0] rdata;
  logic rvalid;
  clock_status_pkg::input_select_type sel;
  clock_status_pkg::alarm_type alarm;
  clock_status_pkg::alarm_mask_type mask;
  logic int_en;
  logic [19:0] ratio;
  logic int_line;
  int n_mismatch;
  int cmp_count;

  // ********
  // Instances
  // ********
  clock_input_status_flags #(.PART_ID(PART_ID), .REVISION(REVISION)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
    .input_select_i(sel), .alarm_i(alarm), .alarm_mask_i(mask),
    .interrupt_enable_i(int_en), .second_input_divide_ratio_o(ratio), .int_o(int_line)
  );
  config_host_model host (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));

  // 10 ns clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ********
  // Helpers
  // ********
  task automatic end_of_test();
    if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // A read that never answers ends the run
  task automatic check_reg(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.read_reg(addr, d, ok);
    check({19'h0, ok}, 20'h1);
    if (!ok) end_of_test();
    check({12'h0, d}, {12'h0, exp});
  endtask : check_reg

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cycles

  // ********
  // Scenarios
  // ********
  // First read is taken on the first edge after release
  task automatic reset_values();
    check_reg(`ACTIVE_INPUT_OFFSET, 8'h20);
    check_reg(`STICKY_LOCK_OFFSET, 8'h02);
    check_reg(`STICKY_LOSS_OFFSET, 8'h00);
    check_reg(8'h85, 8'h00);
    check(ratio, 20'h1);
    check({19'h0, int_line}, 20'h0);
  endtask : reset_values

  task automatic identity();
    host.write_reg(`PART_ID_HIGH_OFFSET, 8'hFF);
    check_reg(`PART_ID_HIGH_OFFSET, PART_ID[11:4]);
    check_reg(`PART_ID_LOW_REV_OFFSET, {PART_ID[3:0], REVISION});
  endtask : identity

  // Reserved top bits of the high byte must drop
  task automatic divider();
    host.write_reg(`DIV_HIGH_OFFSET, 8'hFF);
    host.write_reg(`DIV_MID_OFFSET, 8'h12);
    host.write_reg(`DIV_LOW_OFFSET, 8'h34);
    cycles(2);
    check(ratio, 20'h71235);
    check_reg(`DIV_HIGH_OFFSET, 8'h07);
    check_reg(`DIV_LOW_OFFSET, 8'h34);
    host.write_reg(`DIV_HIGH_OFFSET, 8'h00);
    host.write_reg(`DIV_MID_OFFSET, 8'h00);
    host.write_reg(`DIV_LOW_OFFSET, 8'h00);
    cycles(2);
    check(ratio, 20'h1);
  endtask : divider

  // Every selection, then a selected input that lost its signal
  task automatic selection();
    for (int s = 0; s < 3; s++) begin
      sel <= clock_status_pkg::input_select_type'(s);
      cycles(4);
      check_reg(`ACTIVE_INPUT_OFFSET, {6'h0, s == 2, s == 1});
    end
    alarm <= 4'b1000;
    cycles(4);
    check_reg(`ACTIVE_INPUT_OFFSET, 8'h00);
    sel <= clock_status_pkg::SEL_FIRST;
    alarm <= 4'b0100;
    cycles(4);
    check_reg(`ACTIVE_INPUT_OFFSET, 8'h00);
    alarm <= '0;
    sel <= clock_status_pkg::SEL_NONE;
  endtask : selection

  // Each alarm in turn: live, held, refuses a 1, clears on 0
  task automatic alarms();
    cycles(4);
    host.ack_flags(`STICKY_LOSS_OFFSET, 8'h07);
    host.ack_flags(`STICKY_LOCK_OFFSET, 8'h02);
    check_reg(`STICKY_LOSS_OFFSET, 8'h00);
    check_reg(`STICKY_LOCK_OFFSET, 8'h00);
    for (int b = 0; b < 4; b++) begin
      logic [7:0] live_a;
      logic [7:0] held_a;
      logic [7:0] live_v;
      logic [7:0] held_v;
      live_a = (b == 0) ? `LIVE_LOCK_OFFSET : `LIVE_LOSS_OFFSET;
      held_a = (b == 0) ? `STICKY_LOCK_OFFSET : `STICKY_LOSS_OFFSET;
      live_v = (b == 0) ? 8'h01 : 8'h01 << (b - 1);
      held_v = (b == 0) ? 8'h02 : 8'h01 << (b - 1);
      alarm <= clock_status_pkg::alarm_type'(4'h1 << b);
      cycles(4);
      check_reg(live_a, live_v);
      alarm <= '0;
      cycles(4);
      check_reg(live_a, 8'h00);
      check_reg(held_a, held_v);
      host.write_reg(held_a, 8'hFF);
      check_reg(held_a, held_v);
      host.ack_flags(held_a, 8'hFF);
      check_reg(held_a, 8'h00);
    end
  endtask : alarms

  // Enable and per-flag mask both gate the output
  task automatic interrupts();
    alarm <= 4'b0100;
    cycles(4);
    alarm <= '0;
    cycles(3);
    check({19'h0, int_line}, 20'h0);
    int_en <= 1'b1;
    mask <= 4'b0100;
    cycles(3);
    check({19'h0, int_line}, 20'h0);
    mask <= 4'b1011;
    cycles(3);
    check({19'h0, int_line}, 20'h1);
    host.ack_flags(`STICKY_LOSS_OFFSET, 8'h02);
    cycles(3);
    check({19'h0, int_line}, 20'h0);
    // Unlock flag unmasked; a clear during a live unlock must not stick
    mask <= 4'b1110;
    alarm <= 4'b0001;
    cycles(5);
    check({19'h0, int_line}, 20'h1);
    host.ack_flags(`STICKY_LOCK_OFFSET, 8'h02);
    check_reg(`STICKY_LOCK_OFFSET, 8'h02);
    alarm <= '0;
    cycles(4);
    host.ack_flags(`STICKY_LOCK_OFFSET, 8'h02);
    cycles(3);
    check({19'h0, int_line}, 20'h0);
  endtask : interrupts

  // Main sequence
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    rst_i = 1'b1;
    sel = clock_status_pkg::SEL_NONE;
    alarm = '0;
    mask = '0;
    int_en = 1'b0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    reset_values();
    identity();
    divider();
    selection();
    alarms();
    interrupts();
    end_of_test();
  end
endmodule : clock_input_status_flags_tb
